/* File: design/rsra_buf.sv */
// two-entry skid buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module rsra_buf #(
  parameter int WIDTH = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic skid_valid;
  logic [WIDTH-1:0] skid_data;
  wire drain_ok = out_ready_i | ~out_valid_o;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // ready comes from a flop so the filling side sees no combinational path
  assign in_ready_o = ~skid_valid;

  // output stage refills from the skid entry first to keep word order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
    end else if (drain_ok) begin
      if (skid_valid) begin
        out_valid_o <= 1'b1;
        out_data_o <= skid_data;
        skid_valid <= 1'b0;
      end else begin
        out_valid_o <= in_valid_i;
        if (in_valid_i) begin
          out_data_o <= in_data_i;
        end
      end
    end else if (in_valid_i && !skid_valid) begin
      skid_valid <= 1'b1; // receiver stalled: park the word
      skid_data <= in_data_i;
    end
  end

endmodule : rsra_buf

`default_nettype wire

/* File: design/rsra_pkg.sv */
// shared constants and types for the serial register access target
package rsra_pkg;

  // ----------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] RSRA_TARGET_ADDR = 7'h51; // 1010 001, bytes a2h / a3h
  localparam logic [7:0] RSRA_PTR_LAST = 8'h2f;     // highest valid pointer
  localparam logic [5:0] RSRA_PTR_FIRST = 6'h00;    // pointer after wrap

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RSRA_PTR_W = 6;
  localparam int RSRA_BYTE_W = 8;
  localparam int RSRA_WORD_W = RSRA_PTR_W + RSRA_BYTE_W; // buffered write word

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RSRA_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] RSRA_LAST_TX_BIT = 4'h7;
  localparam logic [3:0] RSRA_BITCNT_RST = 4'h0;
  localparam logic [5:0] RSRA_PTR_RST = 6'h00;
  localparam logic [7:0] RSRA_SHIFT_RST = 8'h00;
  localparam logic RSRA_LINE_IDLE = 1'b1; // both lines idle high

  // ----------------------------------------------------------------
  // byte roles and engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSRA_KIND_ADDR = 2'h0,
    RSRA_KIND_PTR  = 2'h1,
    RSRA_KIND_DATA = 2'h2
  } rsra_kind_e;

  // gray codes along idle -> rx -> ack -> tx -> master ack
  typedef enum logic [2:0] {
    RSRA_ST_IDLE    = 3'h0,
    RSRA_ST_RX      = 3'h1,
    RSRA_ST_ACK     = 3'h3,
    RSRA_ST_TX      = 3'h2,
    RSRA_ST_RACK    = 3'h6,
    RSRA_ST_STRETCH = 3'h5
  } rsra_state_e;

endpackage : rsra_pkg

/* File: design/rsra_slave.sv */
// two-wire serial target front end with auto-incrementing register pointer
//
// Overview of operation
// - each 8-bit byte is followed by one ack slot; low acks, high refuses.
// - when written, target drives ack after address, pointer and each data byte.
// - first byte after write address loads the pointer; valid 00h to 2Fh.
// - out-of-range pointer makes the transfer ignored, but all bytes still acked.
// - a write carries zero or more data bytes, ended by stop or restart.
// - pointer advances by one after each written byte, 2Fh wraps to 00h.
// - a read starts at the pointer left by the previous access.
// - after read address is acked, target sends data at once, no pointer.
// - pointer advances by one after each read byte, 2Fh wraps to 00h.
// - only address 1010 001 answers; a2h writes, a3h reads.
// - on backup battery power the interface stays silent on the bus.
// - start is data falling with clock high; stop is data rising.
`timescale 1ns/10ps
`default_nettype none

module rsra_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  // two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // power state from the supply monitor
  input wire logic on_battery_i,
  // write side toward the register space
  output logic wr_valid_o,
  output logic [rsra_pkg::RSRA_PTR_W-1:0] wr_addr_o,
  output logic [rsra_pkg::RSRA_BYTE_W-1:0] wr_data_o,
  input wire logic wr_ready_i,
  // read side toward the register space
  output logic [rsra_pkg::RSRA_PTR_W-1:0] rd_addr_o,
  input wire logic [rsra_pkg::RSRA_BYTE_W-1:0] rd_data_i,
  output logic rd_strobe_o,
  // status
  output logic busy_o
);
  import rsra_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation and bus events
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic [0:0] batt_s;
  logic scl_q;
  logic sda_q;

  rsra_sync #(
    .WIDTH(2),
    .RST_VAL(RSRA_LINE_IDLE)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );

  // battery flag is also foreign to this clock; idle low after reset
  rsra_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_batt_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(on_battery_i),
    .sync_o(batt_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire on_batt = batt_s[0];

  // delayed copies of the synchronised lines for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= RSRA_LINE_IDLE;
      sda_q <= RSRA_LINE_IDLE;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // data edges count only while the clock stays high across both samples
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // engine registers
  // ----------------------------------------------------------------
  rsra_state_e state;
  rsra_state_e next_state;
  rsra_kind_e kind;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [5:0] ptr;
  logic ignore;
  logic reading;
  logic master_ack;

  // ----------------------------------------------------------------
  // byte decode
  // ----------------------------------------------------------------
  wire byte_done = (bitcnt == RSRA_BITS_PER_BYTE);
  wire addr_hit = (shreg[7:1] == RSRA_TARGET_ADDR);
  wire addr_rd = shreg[0];
  wire ptr_ok = (shreg <= RSRA_PTR_LAST);
  wire [5:0] ptr_inc = (ptr[5:0] == RSRA_PTR_LAST[5:0]) ? RSRA_PTR_FIRST
                                                        : ptr + 6'h01;
  // a data byte of an accepted transfer must go into the buffer
  wire need_push = (kind == RSRA_KIND_DATA) && !ignore;

  // ----------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------
  // a stalled register side stretches the clock instead of dropping bytes
  logic push;
  logic buf_ready;
  logic [RSRA_WORD_W-1:0] push_word;

  assign push_word = {ptr, shreg};

  rsra_buf #(
    .WIDTH(RSRA_WORD_W)
  ) u_wr_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(push_word),
    .in_ready_o(buf_ready),
    .out_valid_o(wr_valid_o),
    .out_data_o({wr_addr_o, wr_data_o}),
    .out_ready_i(wr_ready_i)
  );

  // push on the ack-slot entry of an accepted data byte
  wire rx_end = (state == RSRA_ST_RX) && scl_fall && byte_done;
  wire stretch_go = (state == RSRA_ST_STRETCH) && buf_ready;
  wire rx_push_now = rx_end && need_push && buf_ready;
  assign push = rx_push_now | stretch_go;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // start and stop win over any bit in flight, so a broken byte is dropped
  always_comb begin
    next_state = state;
    if (on_batt) begin
      next_state = RSRA_ST_IDLE;
    end else if (bus_start) begin
      next_state = RSRA_ST_RX;
    end else if (bus_stop) begin
      next_state = RSRA_ST_IDLE;
    end else begin
      case (state)
        RSRA_ST_IDLE: begin
          next_state = RSRA_ST_IDLE;
        end
        RSRA_ST_RX: begin
          if (rx_end) begin
            if (kind == RSRA_KIND_ADDR && !addr_hit) begin
              next_state = RSRA_ST_IDLE;
            end else if (need_push && !buf_ready) begin
              next_state = RSRA_ST_STRETCH;
            end else begin
              next_state = RSRA_ST_ACK;
            end
          end
        end
        RSRA_ST_STRETCH: begin
          if (buf_ready) begin
            next_state = RSRA_ST_ACK;
          end
        end
        RSRA_ST_ACK: begin
          if (scl_fall) begin
            next_state = reading ? RSRA_ST_TX : RSRA_ST_RX;
          end
        end
        RSRA_ST_TX: begin
          if (scl_fall && bitcnt == RSRA_LAST_TX_BIT) begin
            next_state = RSRA_ST_RACK;
          end
        end
        RSRA_ST_RACK: begin
          if (scl_fall) begin
            next_state = master_ack ? RSRA_ST_TX : RSRA_ST_IDLE;
          end
        end
        default: begin
          next_state = RSRA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RSRA_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // bit counter and shift register
  // ----------------------------------------------------------------
  // rx shifts on the rising clock; tx shifts on the falling clock
  wire tx_load = (state == RSRA_ST_ACK && scl_fall && reading) ||
                 (state == RSRA_ST_RACK && scl_fall && master_ack);
  wire tx_shift = (state == RSRA_ST_TX) && scl_fall && bitcnt != RSRA_LAST_TX_BIT;

  always_ff @(posedge clk_i) begin
    if (rst_i || bus_start || bus_stop) begin
      bitcnt <= RSRA_BITCNT_RST;
      shreg <= RSRA_SHIFT_RST;
    end else if (state == RSRA_ST_RX && scl_rise) begin
      bitcnt <= bitcnt + 4'h1;
      shreg <= {shreg[6:0], sda_s};
    end else if (state == RSRA_ST_ACK && scl_fall) begin
      bitcnt <= RSRA_BITCNT_RST;
      if (reading) begin
        shreg <= rd_data_i;
      end
    end else if (tx_load) begin
      bitcnt <= RSRA_BITCNT_RST;
      shreg <= rd_data_i;
    end else if (tx_shift) begin
      bitcnt <= bitcnt + 4'h1;
      shreg <= {shreg[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // transfer role, pointer and ignore flag
  // ----------------------------------------------------------------
  // the pointer survives stop and start so a read resumes where the
  // last access left it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind <= RSRA_KIND_ADDR;
      reading <= 1'b0;
      ignore <= 1'b0;
      ptr <= RSRA_PTR_RST;
    end else if (bus_start) begin
      kind <= RSRA_KIND_ADDR;
      reading <= 1'b0;
      ignore <= 1'b0;
    end else if (rx_end) begin
      case (kind)
        RSRA_KIND_ADDR: begin
          reading <= addr_rd;
          kind <= RSRA_KIND_PTR;
        end
        RSRA_KIND_PTR: begin
          kind <= RSRA_KIND_DATA;
          if (ptr_ok) begin
            ptr <= shreg[5:0];
          end else begin
            ignore <= 1'b1;
          end
        end
        RSRA_KIND_DATA: begin
          if (need_push && buf_ready) begin
            ptr <= ptr_inc;
          end
        end
        default: begin
          kind <= RSRA_KIND_ADDR;
        end
      endcase
    end else if (stretch_go) begin
      ptr <= ptr_inc;
    end else if (state == RSRA_ST_TX && scl_fall && bitcnt == RSRA_LAST_TX_BIT) begin
      ptr <= ptr_inc;
    end
  end

  // ----------------------------------------------------------------
  // controller acknowledge sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_ack <= 1'b0;
    end else if (state == RSRA_ST_RACK && scl_rise) begin
      master_ack <= ~sda_s;
    end
  end

  // ----------------------------------------------------------------
  // line drivers
  // ----------------------------------------------------------------
  // lines are open drain: only low is ever driven, so the level is fixed
  // ack is pulled during the stretch too, so it never falls as the clock is let go
  wire drive_ack = (next_state == RSRA_ST_ACK) || (next_state == RSRA_ST_STRETCH);
  wire [7:0] tx_byte = tx_load ? rd_data_i : (tx_shift ? {shreg[6:0], 1'b0} : shreg);
  wire drive_tx = (next_state == RSRA_ST_TX) && !tx_byte[7];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
      sda_oe_o <= drive_ack | drive_tx;
      scl_oe_o <= (next_state == RSRA_ST_STRETCH);
    end
  end

  // ----------------------------------------------------------------
  // register-side outputs
  // ----------------------------------------------------------------
  // the read address follows the pointer; the strobe marks each byte taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_addr_o <= RSRA_PTR_RST;
      rd_strobe_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      rd_addr_o <= ptr;
      rd_strobe_o <= tx_load;
      busy_o <= (next_state != RSRA_ST_IDLE);
    end
  end

endmodule : rsra_slave

`default_nettype wire

/* File: design/rsra_sync.sv */
// two-flop synchroniser for pin inputs, one chain per bit
`timescale 1ns/10ps
`default_nettype none

module rsra_sync #(
  parameter int WIDTH = 2,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // per-bit chains
  // ----------------------------------------------------------------
  // first stage feeds only the second; nothing else may look at it
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic meta;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta <= RST_VAL;
          sync_o[gi] <= RST_VAL;
        end else begin
          meta <= async_i[gi];
          sync_o[gi] <= meta;
        end
      end
    end
  endgenerate

endmodule : rsra_sync

`default_nettype wire

/* File: dv/rsra_host_model.sv */
// bus controller model driving the two-wire lines of the target
`timescale 1ns/10ps
`default_nettype none

module rsra_host_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_drv_o,
  output logic sda_drv_o
);
  // ----------------------------------------------------------
  // line timing
  // ----------------------------------------------------------
  // ten clocks a half period keeps clear of the target's sync delay
  localparam int HALF = 10;
  initial begin
    scl_drv_o = 1'b1;
    sda_drv_o = 1'b1;
  end
  task automatic hp();
    repeat (HALF) @(posedge clk_i);
    #1;
  endtask : hp
  // release the clock and wait, bounded, while the target stretches it
  task automatic rise();
    scl_drv_o = 1'b1;
    for (int i = 0; i < 1000 && scl_i !== 1'b1; i++) @(posedge clk_i);
    hp();
  endtask : rise
  // one bit slot: data set in the low phase, sampled at the end of high
  task automatic slot(input logic b, output logic r);
    sda_drv_o = b;
    hp();
    rise();
    r = sda_i;
    scl_drv_o = 1'b0;
    hp();
  endtask : slot
  // ----------------------------------------------------------
  // framing
  // ----------------------------------------------------------
  task automatic start();
    sda_drv_o = 1'b1;
    hp();
    rise();
    sda_drv_o = 1'b0;
    hp();
    scl_drv_o = 1'b0;
    hp();
  endtask : start
  task automatic stop();
    sda_drv_o = 1'b0;
    hp();
    rise();
    sda_drv_o = 1'b1;
    hp();
  endtask : stop
  // n below 8 leaves the byte unfinished on purpose
  task automatic wr(input logic [7:0] v, output logic ack, input int n = 8);
    logic r;
    ack = 1'b1;
    for (int i = 7; i > 7 - n; i--) slot(v[i], r);
    if (n == 8) slot(1'b1, ack);
  endtask : wr
  // every byte is acked except the last one wanted
  task automatic rd(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) slot(1'b1, v[i]);
    slot(last, r);
  endtask : rd
endmodule : rsra_host_model
`default_nettype wire

/* File: dv/rsra_slave_sva.sv */
// concurrent checks on the ports of the serial register access target
`timescale 1ns/10ps
`default_nettype none

module rsra_slave_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic on_battery_i,
  input wire logic wr_valid_o,
  input wire logic [rsra_pkg::RSRA_PTR_W-1:0] wr_addr_o,
  input wire logic [rsra_pkg::RSRA_BYTE_W-1:0] wr_data_o,
  input wire logic wr_ready_i,
  input wire logic [rsra_pkg::RSRA_PTR_W-1:0] rd_addr_o,
  input wire logic [rsra_pkg::RSRA_BYTE_W-1:0] rd_data_i,
  input wire logic rd_strobe_o,
  input wire logic busy_o
);
  import rsra_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------
  // bus conditions on the pins
  // ----------------------------------------------------------
  sequence start_seen;
    scl_i && $fell(sda_i);
  endsequence
  sequence stop_seen;
    scl_i && $rose(sda_i);
  endsequence
  sequence scl_held;
    scl_i [*2];
  endsequence
  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_start_busy: assert property (start_seen ##0 !on_battery_i |-> ##[1:8] busy_o)
    else $error("no busy after start");
  a_stop_idle: assert property (stop_seen |-> ##[1:8] !busy_o)
    else $error("still busy after stop");
  // data may only move while the clock is low, else it reads as start or stop
  a_sda_steady: assert property (scl_held |-> $stable(sda_oe_o))
    else $error("data drive changed with clock high");
  a_sda_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data driven high");
  a_stretch_full: assert property (scl_oe_o |-> wr_valid_o && !scl_o)
    else $error("clock held without pending word");
  a_word_hold: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable({wr_addr_o, wr_data_o}))
    else $error("write word dropped or changed");
  a_batt_quiet: assert property (on_battery_i [*5] |-> !sda_oe_o && !scl_oe_o && !busy_o)
    else $error("bus driven on backup supply");
  a_strobe_once: assert property (rd_strobe_o |-> busy_o ##1 !rd_strobe_o [*8])
    else $error("read load not a single pulse");
  a_reset_quiet: assert property ($fell(rst_i) |-> !busy_o && rd_addr_o == RSRA_PTR_RST)
    else $error("state not cleared by reset");
endmodule : rsra_slave_chk

bind rsra_slave rsra_slave_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .on_battery_i(on_battery_i), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
  .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i), .rd_addr_o(rd_addr_o),
  .rd_data_i(rd_data_i), .rd_strobe_o(rd_strobe_o), .busy_o(busy_o));
`default_nettype wire

/* File: dv/rsra_slave_tb.sv */
// self-checking bench for the serial register access target
`timescale 1ns/10ps
`default_nettype none

module rsra_slave_tb;
  import rsra_pkg::*;
  logic clk_i, rst_i, on_batt, stall, h_scl, h_sda, scl_line, sda_line;
  logic scl_oe, scl_o, sda_oe, sda_o, wr_valid, rd_strobe, busy;
  logic [RSRA_PTR_W-1:0] wr_addr, rd_addr;
  logic [RSRA_BYTE_W-1:0] wr_data, rd_data;
  logic [RSRA_BYTE_W-1:0] regs [48];
  logic [13:0] words [$];
  int miscompares, n_compared, n_strobe;
  // ----------------------------------------------------------
  // lines, register side and parties
  // ----------------------------------------------------------
  // open-drain lines with pull-ups: low while any party pulls
  assign scl_line = h_scl & ~(scl_oe & ~scl_o);
  assign sda_line = h_sda & ~(sda_oe & ~sda_o);
  assign rd_data = (rd_addr < 6'h30) ? regs[rd_addr] : 8'hee;
  // register side takes a word whenever it is not stalling
  always @(posedge clk_i) begin
    if (!rst_i && wr_valid === 1'b1 && !stall) begin
      regs[wr_addr] <= wr_data;
      words.push_back({wr_addr, wr_data});
    end
  end
  // count read loads so the two bytes sent in t_read are seen to fetch exactly once
  always @(posedge clk_i) begin
    if (!rst_i && rd_strobe === 1'b1) n_strobe++;
  end
  rsra_host_model i_host (.clk_i(clk_i), .scl_i(scl_line), .sda_i(sda_line),
    .scl_drv_o(h_scl), .sda_drv_o(h_sda));
  rsra_slave i_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .on_battery_i(on_batt), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_ready_i(~stall), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .rd_strobe_o(rd_strobe), .busy_o(busy));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_once(input logic [7:0] exp);
    logic a;
    logic [7:0] v;
    i_host.start();
    i_host.wr(8'ha3, a);
    i_host.rd(1'b1, v);
    chk("single read", {6'h00, exp}, {6'h00, v});
    i_host.stop();
  endtask : rd_once
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  // three bytes from 2eh with the register side stalled: the third must
  // wait in a stretched clock, and the addresses wrap past 2fh
  task automatic t_write();
    logic a;
    logic [7:0] d [3] = '{8'h11, 8'h22, 8'h33};
    words.delete();
    stall = 1'b1;
    i_host.start();
    i_host.wr(8'ha2, a);
    chk("write address ack", 14'h0, 14'(a));
    i_host.wr(8'h2e, a);
    chk("pointer ack", 14'h0, 14'(a));
    fork
      begin
        cyc(1200);
        stall = 1'b0;
      end
    join_none
    foreach (d[i]) begin
      i_host.wr(d[i], a);
      chk("data ack", 14'h0, 14'(a));
    end
    i_host.stop();
    cyc(20);
    chk("word count", 14'h3, 14'(words.size()));
    foreach (d[i]) chk("write word", {6'((8'h2e + i) % 8'h30), d[i]}, words[i]);
  endtask : t_write
  // pointer-only write to 2fh, restart, read across the wrap, read on
  task automatic t_read();
    logic a;
    logic [7:0] v;
    int s;
    s = n_strobe;
    i_host.start();
    i_host.wr(8'ha2, a);
    i_host.wr(8'h2f, a);
    i_host.start();
    i_host.wr(8'ha3, a);
    chk("read address ack", 14'h0, 14'(a));
    i_host.rd(1'b0, v);
    chk("first read", 14'h22, 14'(v));
    i_host.rd(1'b1, v);
    chk("wrapped read", 14'h33, 14'(v));
    chk("data released", 14'h0, 14'(sda_oe));
    chk("read loads", 14'h2, 14'(n_strobe - s));
    i_host.stop();
    rd_once(8'h81);
  endtask : t_read
  // pointer 30h: every byte acked, nothing written, pointer kept
  task automatic t_bad_ptr();
    logic a;
    logic [7:0] b [3] = '{8'ha2, 8'h30, 8'h44};
    words.delete();
    i_host.start();
    foreach (b[i]) begin
      i_host.wr(b[i], a);
      chk("out of range ack", 14'h0, 14'(a));
    end
    i_host.stop();
    cyc(20);
    chk("ignored words", 14'h0, 14'(words.size()));
    rd_once(8'h82);
  endtask : t_bad_ptr
  // restart after four bits of a data byte drops the byte
  task automatic t_abort();
    logic a;
    words.delete();
    i_host.start();
    i_host.wr(8'ha2, a);
    i_host.wr(8'h05, a);
    i_host.wr(8'h99, a, 4);
    i_host.start();
    i_host.stop();
    rd_once(8'h85);
    chk("aborted words", 14'h0, 14'(words.size()));
  endtask : t_abort
  // foreign addresses, then the right one on backup supply, stay unanswered
  task automatic t_refuse();
    logic a;
    logic [7:0] b [4] = '{8'ha0, 8'h22, 8'ha6, 8'ha2};
    foreach (b[i]) begin
      on_batt = (i == 3);
      cyc(5);
      i_host.start();
      i_host.wr(b[i], a);
      chk("refused address", 14'h1, 14'(a));
      i_host.stop();
    end
    on_batt = 1'b0;
    cyc(5);
    rd_once(8'h86);
  endtask : t_refuse
  // ----------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    miscompares = 0;
    n_compared = 0;
    rst_i = 1'b1;
    on_batt = 1'b0;
    stall = 1'b0;
    foreach (regs[i]) regs[i] = 8'h80 | 8'(i);
    cyc(5);
    rst_i = 1'b0;
    cyc(5);
    t_write();
    t_read();
    t_bad_ptr();
    t_abort();
    t_refuse();
    complete_run();
  end
  // the sequence needs some 9000 cycles, so this leaves wide margin
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
endmodule : rsra_slave_tb
`default_nettype wire
